/* File: dv/lfl_host_model.sv */
`timescale 1ns/1ps
// Host side: pulses the disable pin for a chosen hold time
module lfl_host_model (
    // Clock
    input wire logic mclk,
    // Command from bench
    input wire logic go,
    input wire logic [7:0] hold,
    // Disable pin and status
    output logic transmit_disable_pin = 1'b0,
    output logic busy
);
    logic [7:0] cnt = 8'h00;

    // Hold disable for hold+1 cycles, never shorter than asked
    always_ff @(posedge mclk) begin
        if (go) begin
            cnt <= hold;
            transmit_disable_pin <= 1'b1;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end else begin
            transmit_disable_pin <= 1'b0;
        end
    end

    assign busy = transmit_disable_pin;
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, mon = 1'b0, go = 1'b0, fault_output, irq, dis, busy;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [7:0] pd_meas = 8'h00;
    logic [8:0] mod_step;
    logic [3:0] xpt;
    logic signed [4:0] slope;
    lfl_pkg::lfl_drive_t drive;
    int n_fail = 0, num_checks = 0;

    lfl_top #(.CLEAR_CYC(4), .NEGATE_CYC(2)) dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .transmit_disable_pin(dis), .mon_above_ref_pin(mon), .pd_meas(pd_meas),
        .drive(drive), .mod_step(mod_step), .xpt_span_sel(xpt), .tsensor_slope_offset(slope),
        .fault_output(fault_output), .irq(irq));
    lfl_host_model host (.mclk(mclk), .go(go), .hold(8'h08), .transmit_disable_pin(dis), .busy(busy));

    // ----------------------------------------
    // Clock, shared tasks
    // ----------------------------------------
    initial forever #2.5 mclk = ~mclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        rd <= 1'b1; addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Host disable pulse, waits for its end and the wake delay
    task automatic recover();
        @(posedge mclk);
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        tick(5);
        check(fault_output, 0);
        for (int i = 0; i < 50 && busy; i++) tick(1);
        tick(12);
    endtask

    task automatic tally_and_finish();
        if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        logic [15:0] d;
        logic [8:0] stp[4] = '{lfl_pkg::MOD_SCALE_FULL, lfl_pkg::MOD_SCALE_0833, lfl_pkg::MOD_SCALE_066,
            lfl_pkg::MOD_SCALE_05};
        logic [4:0] mg;
        tick(4);
        rst <= 1'b0;
        // Reset state, unmapped and read-only places
        rd_reg(4'h0, d); check(d, 16'h0003);
        wr_reg(4'h6, 16'hffff);
        rd_reg(4'h6, d); check(d, 16'h0000);
        rd_reg(4'hf, d); check(d, 16'h0000);
        check(fault_output, 0);
        wr_reg(4'h1, 16'h0080); wr_reg(4'h2, 16'h0040); wr_reg(4'h3, 16'h0020);
        // Every range and span code, four slope codes
        for (int i = 3; i >= 0; i--) begin
            mg = 5'(i * 5);
            wr_reg(4'h5, {7'h00, i[0], mg[3:0], 2'(i), 2'(i)});
            tick(3);
            check(mod_step, stp[i]);
            check(drive.modul, (16'h0040 * stp[i]) >> 8);
            check(xpt, 4'h1 << i);
            check({27'h0, slope}, i[0] ? mg : 5'(5'h00 - mg));
        end
        check(drive, 24'h804020);
        // Monitor fault, latch, interrupt bits
        mon <= 1'b1;
        tick(8);
        check(fault_output, 1);
        check(drive, 24'h000000);
        rd_reg(4'h7, d); check(d, 16'h0009);
        wr_reg(4'h8, 16'h0008);
        rd_reg(4'h8, d); check(d, 16'h0008);
        check(irq, 1);
        wr_reg(4'h7, 16'h000f);
        rd_reg(4'h7, d); check(d, 16'h0000);
        check(irq, 0);
        // Release with fault live, then with fault gone
        recover();
        check(fault_output, 1);
        check(drive, 24'h000000);
        mon <= 1'b0;
        tick(4);
        recover();
        check(fault_output, 0);
        check(drive, 24'h804020);
        // Handling disabled: no forcing, no latch
        wr_reg(4'h0, 16'h0001);
        mon <= 1'b1;
        tick(8);
        check(fault_output, 0);
        check(drive.bias, 8'h80);
        mon <= 1'b0;
        // Let the synchronised condition fall before handling returns
        tick(4);
        wr_reg(4'h0, 16'h0003);
        tick(8);
        // Photodiode limit boundary
        wr_reg(4'h4, 16'h000a);
        pd_meas <= 8'h0f;
        tick(6);
        check(fault_output, 0);
        pd_meas <= 8'h10;
        tick(6);
        check(fault_output, 1);
        pd_meas <= 8'h00;
        recover();
        check(fault_output, 0);
        // Bias drop boundary, recovery through the enable bit
        wr_reg(4'h1, 16'h0040);
        tick(6);
        check(fault_output, 0);
        wr_reg(4'h1, 16'h001f);
        tick(6);
        check(fault_output, 1);
        wr_reg(4'h0, 16'h0002);
        tick(8);
        check(fault_output, 0);
        wr_reg(4'h0, 16'h0003);
        tick(12);
        check(drive.bias, 8'h1f);
        tally_and_finish();
    end
endmodule

/* File: rtl/lfl_fault_detect.sv */
`timescale 1ns/1ps
module lfl_fault_detect #(
    parameter int DAC_W = lfl_pkg::DAC_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Comparator pin, monitor node above reference
    input wire logic mon_above_ref_pin,
    // Photodiode measurement and limit
    input wire logic [DAC_W-1:0] pd_meas,
    input wire logic [DAC_W-1:0] pd_set,
    // Bias update
    input wire logic bias_wr,
    input wire logic [DAC_W-1:0] bias_new,
    input wire logic [DAC_W-1:0] bias_old,
    // Fault conditions
    output lfl_pkg::lfl_cond_t cond
);

    // Refuse widths the compares cannot serve
    if (DAC_W < 2) begin : g_bad_width
        $error("lfl_fault_detect DAC_W too small");
    end

    logic mon_s1;
    logic mon_s2;
    logic [DAC_W+1:0] pd_twice;
    logic [DAC_W+1:0] set_thrice;
    logic [DAC_W:0] new_twice;

    // Two-stage synchroniser for the comparator pin
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mon_s1 <= 1'b0;
            mon_s2 <= 1'b0;
        end else begin
            mon_s1 <= mon_above_ref_pin;
            mon_s2 <= mon_s1;
        end
    end

    // Scaled operands for the compares
    assign pd_twice = {1'b0, pd_meas, 1'b0};
    assign set_thrice = {2'b00, pd_set} + {1'b0, pd_set, 1'b0};
    assign new_twice = {bias_new, 1'b0};

    // Registered fault conditions
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cond <= '0;
        end else begin
            cond.mon_over <= mon_s2;
            cond.pd_over <= pd_twice > set_thrice;
            cond.dac_drop <= bias_wr && (new_twice < {1'b0, bias_old});
        end
    end

endmodule

/* File: rtl/lfl_pkg.sv */
package lfl_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int DAC_W = 8;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_BIAS = 4'h1;
    localparam logic [ADDR_W-1:0] REG_MOD = 4'h2;
    localparam logic [ADDR_W-1:0] REG_PEAK = 4'h3;
    localparam logic [ADDR_W-1:0] REG_PD_SET = 4'h4;
    localparam logic [ADDR_W-1:0] REG_RANGE = 4'h5;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h6;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h7;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h8;
    localparam logic [ADDR_W-1:0] REG_PD_MEAS = 4'h9;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int CTRL_ENA_BIT = 0;
    localparam int CTRL_FAULT_HANDLING_ENABLE_BIT = 1;
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0003;
    localparam logic [DATA_W-1:0] RANGE_RESET = 16'h0000;
    localparam logic [DAC_W-1:0] DAC_RESET = 8'h00;
    localparam int RNG_MOD_LSB = 0;
    localparam int RNG_XPT_LSB = 2;
    localparam int RNG_SLOPE_LSB = 4;
    localparam int RNG_SIGN_BIT = 8;
    localparam int IRQ_W = 4;
    localparam int IRQ_MON = 0;
    localparam int IRQ_PD = 1;
    localparam int IRQ_DROP = 2;
    localparam int IRQ_FAULT = 3;

    // ----------------------------------------
    // Modulation scale factors, in 1/256
    // ----------------------------------------
    localparam logic [8:0] MOD_SCALE_FULL = 9'h100;
    localparam logic [8:0] MOD_SCALE_0833 = 9'h0d5;
    localparam logic [8:0] MOD_SCALE_066 = 9'h0a9;
    localparam logic [8:0] MOD_SCALE_05 = 9'h080;
    localparam int MOD_SCALE_SHIFT = 8;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CLEAR_TIME_NS = 10000;
    localparam int NEGATE_TIME_NS = 1000;
    localparam int CLEAR_CYC = (CLEAR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int NEGATE_CYC = (NEGATE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        LFL_RUN = 2'b00,
        LFL_FAULT = 2'b01,
        LFL_OFF = 2'b10,
        LFL_WAKE = 2'b11
    } lfl_state_t;

    typedef struct packed {
        logic dac_drop;
        logic pd_over;
        logic mon_over;
    } lfl_cond_t;

    typedef struct packed {
        logic [DAC_W-1:0] bias;
        logic [DAC_W-1:0] modul;
        logic [DAC_W-1:0] peak;
    } lfl_drive_t;

endpackage

/* File: rtl/lfl_range_decode.sv */
`timescale 1ns/1ps
module lfl_range_decode #(
    parameter int DAC_W = lfl_pkg::DAC_W
) (
    // Settings
    input wire logic [DAC_W-1:0] mod_code,
    input wire logic [1:0] modulation_range_reduce,
    input wire logic [1:0] crossing_adjust_span,
    input wire logic tsensor_slope_sign,
    input wire logic [3:0] tsensor_slope_magnitude,
    // Decoded values
    output logic [DAC_W-1:0] mod_scaled,
    output logic [8:0] mod_step,
    output logic [3:0] xpt_span_sel,
    output logic signed [4:0] tsensor_slope_offset
);

    logic [DAC_W+8:0] product;
    logic signed [4:0] mag_ext;

    // Range and step reduction factor
    always_comb begin
        case (modulation_range_reduce)
            2'b00: mod_step = lfl_pkg::MOD_SCALE_FULL;
            2'b01: mod_step = lfl_pkg::MOD_SCALE_0833;
            2'b10: mod_step = lfl_pkg::MOD_SCALE_066;
            2'b11: mod_step = lfl_pkg::MOD_SCALE_05;
            default: mod_step = lfl_pkg::MOD_SCALE_FULL;
        endcase
    end

    // Scaled modulation code
    assign product = {9'h000, mod_code} * {{DAC_W{1'b0}}, mod_step};
    assign mod_scaled = product[lfl_pkg::MOD_SCALE_SHIFT +: DAC_W];

    // One-hot span select, lowest bit is the narrowest span
    always_comb begin
        xpt_span_sel = 4'h0;
        xpt_span_sel[crossing_adjust_span] = 1'b1;
    end

    // Signed slope shift, sign zero means negative
    assign mag_ext = $signed({1'b0, tsensor_slope_magnitude});
    assign tsensor_slope_offset = tsensor_slope_sign ? mag_ext : -mag_ext;

endmodule

/* File: rtl/lfl_top.sv */
`timescale 1ns/1ps
// How it works
// - Flag fault while monitor node voltage exceeds the tempco reference node.
// - Flag fault while photodiode current exceeds 150 percent of its set value.
// - Flag fault when bias DAC drops by more than half in one write.
// - Any fault with handling enabled forces bias, modulation, peaking to zero.
// - Qualifying fault raises fault output and latches it until recovery.
// - Fault output stays low while disable pin high or enable bit low.
// - Fault gone at release: resume prior settings after the negate time.
// - Fault still present at release: fault output returns, stay stopped.
// - Modulation range field scales range and step by 1, 0.833, 0.66, 0.5.
// - Cross point span field: 00 narrowest, 11 widest.
// - Slope adjust: sign bit zero means negative, four-bit magnitude.
module lfl_top #(
    parameter int DAC_W = lfl_pkg::DAC_W,
    parameter int CLEAR_CYC = lfl_pkg::CLEAR_CYC,
    parameter int NEGATE_CYC = lfl_pkg::NEGATE_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [lfl_pkg::ADDR_W-1:0] addr,
    input wire logic [lfl_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [lfl_pkg::DATA_W-1:0] rdata,
    // Pins and measurement
    input wire logic transmit_disable_pin,
    input wire logic mon_above_ref_pin,
    input wire logic [DAC_W-1:0] pd_meas,
    // Current drive
    output lfl_pkg::lfl_drive_t drive,
    // Analog settings
    output logic [8:0] mod_step,
    output logic [3:0] xpt_span_sel,
    output logic signed [4:0] tsensor_slope_offset,
    // Fault and interrupt
    output logic fault_output,
    output logic irq
);

    localparam int TMR_MAX = (CLEAR_CYC > NEGATE_CYC) ? CLEAR_CYC : NEGATE_CYC;
    localparam int TMR_W = $clog2(TMR_MAX + 1);
    localparam logic [TMR_W-1:0] CLEAR_LAST = TMR_W'(CLEAR_CYC - 1);
    localparam logic [TMR_W-1:0] NEGATE_LAST = TMR_W'(NEGATE_CYC - 1);

    // Refuse timing counts and widths the logic cannot serve
    if (CLEAR_CYC < 1 || NEGATE_CYC < 1 || DAC_W < 2 || DAC_W > lfl_pkg::DATA_W) begin : g_bad_params
        $error("lfl_top parameters out of range");
    end
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [lfl_pkg::DATA_W-1:0] ctrl;
    logic [lfl_pkg::DATA_W-1:0] range_cfg;
    logic [DAC_W-1:0] bias_code;
    logic [DAC_W-1:0] mod_code;
    logic [DAC_W-1:0] peak_code;
    logic [DAC_W-1:0] pd_set;
    logic [lfl_pkg::IRQ_W-1:0] irq_stat;
    logic [lfl_pkg::IRQ_W-1:0] irq_mask;
    logic [lfl_pkg::IRQ_W-1:0] irq_event;
    logic [lfl_pkg::IRQ_W-1:0] irq_clear;
    logic dis_s1;
    logic dis_s2;
    logic disabled;
    logic fault_handling_enable;
    logic internal_enable_bit;
    logic qualifying;
    logic fault_latch;
    logic fault_latch_d;
    logic bias_wr;
    lfl_pkg::lfl_cond_t cond;
    lfl_pkg::lfl_cond_t cond_d;
    lfl_pkg::lfl_state_t state;
    lfl_pkg::lfl_state_t next_state;
    logic [TMR_W-1:0] tmr;
    logic [DAC_W-1:0] mod_scaled;
    logic [8:0] dec_step;
    logic [3:0] dec_span;
    logic signed [4:0] dec_slope;
    logic [lfl_pkg::DATA_W-1:0] next_rdata;

    // ----------------------------------------
    // Pin synchroniser and control decode
    // ----------------------------------------
    // Two flops on the disable pin
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dis_s1 <= 1'b0;
            dis_s2 <= 1'b0;
        end else begin
            dis_s1 <= transmit_disable_pin;
            dis_s2 <= dis_s1;
        end
    end

    assign internal_enable_bit = ctrl[lfl_pkg::CTRL_ENA_BIT];
    assign fault_handling_enable = ctrl[lfl_pkg::CTRL_FAULT_HANDLING_ENABLE_BIT];
    assign disabled = dis_s2 || !internal_enable_bit;
    assign qualifying = (cond.mon_over || cond.pd_over || cond.dac_drop) && fault_handling_enable;
    assign bias_wr = wr && (addr == lfl_pkg::REG_BIAS);

    // ----------------------------------------
    // Fault detection and settings decode
    // ----------------------------------------
    lfl_fault_detect #(
        .DAC_W(DAC_W)
    ) u_detect (
        .mclk(mclk),
        .rst(rst),
        .mon_above_ref_pin(mon_above_ref_pin),
        .pd_meas(pd_meas),
        .pd_set(pd_set),
        .bias_wr(bias_wr),
        .bias_new(wdata[DAC_W-1:0]),
        .bias_old(bias_code),
        .cond(cond)
    );

    lfl_range_decode #(
        .DAC_W(DAC_W)
    ) u_decode (
        .mod_code(mod_code),
        .modulation_range_reduce(range_cfg[lfl_pkg::RNG_MOD_LSB +: 2]),
        .crossing_adjust_span(range_cfg[lfl_pkg::RNG_XPT_LSB +: 2]),
        .tsensor_slope_sign(range_cfg[lfl_pkg::RNG_SIGN_BIT]),
        .tsensor_slope_magnitude(range_cfg[lfl_pkg::RNG_SLOPE_LSB +: 4]),
        .mod_scaled(mod_scaled),
        .mod_step(dec_step),
        .xpt_span_sel(dec_span),
        .tsensor_slope_offset(dec_slope)
    );

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    // Writable settings, kept through faults
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl <= lfl_pkg::CTRL_RESET;
            range_cfg <= lfl_pkg::RANGE_RESET;
            bias_code <= lfl_pkg::DAC_RESET;
            mod_code <= lfl_pkg::DAC_RESET;
            peak_code <= lfl_pkg::DAC_RESET;
            pd_set <= lfl_pkg::DAC_RESET;
        end else if (wr) begin
            case (addr)
                lfl_pkg::REG_CTRL: ctrl <= wdata;
                lfl_pkg::REG_RANGE: range_cfg <= wdata;
                lfl_pkg::REG_BIAS: bias_code <= wdata[DAC_W-1:0];
                lfl_pkg::REG_MOD: mod_code <= wdata[DAC_W-1:0];
                lfl_pkg::REG_PEAK: peak_code <= wdata[DAC_W-1:0];
                lfl_pkg::REG_PD_SET: pd_set <= wdata[DAC_W-1:0];
                default: ;
            endcase
        end
    end

    // Read mux, data valid only in the cycle after the strobe
    always_comb begin
        next_rdata = '0;
        case (addr)
            lfl_pkg::REG_CTRL: next_rdata = ctrl;
            lfl_pkg::REG_RANGE: next_rdata = range_cfg;
            lfl_pkg::REG_BIAS: next_rdata[DAC_W-1:0] = bias_code;
            lfl_pkg::REG_MOD: next_rdata[DAC_W-1:0] = mod_code;
            lfl_pkg::REG_PEAK: next_rdata[DAC_W-1:0] = peak_code;
            lfl_pkg::REG_PD_SET: next_rdata[DAC_W-1:0] = pd_set;
            lfl_pkg::REG_PD_MEAS: next_rdata[DAC_W-1:0] = pd_meas;
            lfl_pkg::REG_STATUS: next_rdata[7:0] = {dis_s2, fault_latch, state, 1'b0, cond};
            lfl_pkg::REG_IRQ_STAT: next_rdata[lfl_pkg::IRQ_W-1:0] = irq_stat;
            lfl_pkg::REG_IRQ_MASK: next_rdata[lfl_pkg::IRQ_W-1:0] = irq_mask;
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= rd ? next_rdata : '0;
        end
    end

    // ----------------------------------------
    // Fault latch state machine
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            lfl_pkg::LFL_RUN: begin
                if (disabled) begin
                    next_state = lfl_pkg::LFL_OFF;
                end else if (qualifying) begin
                    next_state = lfl_pkg::LFL_FAULT;
                end
            end
            lfl_pkg::LFL_FAULT: begin
                if (disabled) begin
                    next_state = lfl_pkg::LFL_OFF;
                end
            end
            lfl_pkg::LFL_OFF: begin
                if (!disabled) begin
                    if (fault_latch || qualifying) begin
                        next_state = lfl_pkg::LFL_FAULT;
                    end else begin
                        next_state = lfl_pkg::LFL_WAKE;
                    end
                end
            end
            lfl_pkg::LFL_WAKE: begin
                if (disabled) begin
                    next_state = lfl_pkg::LFL_OFF;
                end else if (qualifying) begin
                    next_state = lfl_pkg::LFL_FAULT;
                end else if (tmr == NEGATE_LAST) begin
                    next_state = lfl_pkg::LFL_RUN;
                end
            end
            default: next_state = lfl_pkg::LFL_RUN;
        endcase
    end

    // State register, normal operation after reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= lfl_pkg::LFL_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Shared timer for clear hold and turn-on delay
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tmr <= '0;
        end else if (next_state != state) begin
            tmr <= '0;
        end else if (state == lfl_pkg::LFL_OFF || state == lfl_pkg::LFL_WAKE) begin
            if (tmr != TMR_W'(TMR_MAX)) begin
                tmr <= tmr + 1'b1;
            end
        end
    end

    // Latch sets on a qualifying fault, clears after a long enough disable
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fault_latch <= 1'b0;
        end else if (next_state == lfl_pkg::LFL_FAULT) begin
            fault_latch <= 1'b1;
        end else if (state == lfl_pkg::LFL_OFF && disabled && tmr == CLEAR_LAST) begin
            fault_latch <= 1'b0;
        end
    end

    // Fault pin masked while disabled
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fault_output <= 1'b0;
        end else begin
            fault_output <= fault_latch && !disabled;
        end
    end

    // ----------------------------------------
    // Current drive and analog settings
    // ----------------------------------------
    // Drive only in normal operation, settings restored on return
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            drive <= '0;
        end else if (state == lfl_pkg::LFL_RUN && !qualifying) begin
            drive.bias <= bias_code;
            drive.modul <= mod_scaled;
            drive.peak <= peak_code;
        end else begin
            drive <= '0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mod_step <= lfl_pkg::MOD_SCALE_FULL;
            xpt_span_sel <= 4'h1;
            tsensor_slope_offset <= '0;
        end else begin
            mod_step <= dec_step;
            xpt_span_sel <= dec_span;
            tsensor_slope_offset <= dec_slope;
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    // Rising edges of monitor, photodiode and latch, drop condition as is, clear strobe
    assign irq_event[lfl_pkg::IRQ_MON] = cond.mon_over && !cond_d.mon_over;
    assign irq_event[lfl_pkg::IRQ_PD] = cond.pd_over && !cond_d.pd_over;
    assign irq_event[lfl_pkg::IRQ_DROP] = cond.dac_drop;
    assign irq_event[lfl_pkg::IRQ_FAULT] = fault_latch && !fault_latch_d;
    assign irq_clear = (wr && addr == lfl_pkg::REG_IRQ_STAT) ? wdata[lfl_pkg::IRQ_W-1:0] : '0;

    // Sticky status, write one to clear, new event wins; delayed copies feed the edge detect
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cond_d <= '0;
            fault_latch_d <= 1'b0;
            irq_stat <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
        end else begin
            cond_d <= cond;
            fault_latch_d <= fault_latch;
            irq_stat <= (irq_stat & ~irq_clear) | irq_event;
            if (wr && addr == lfl_pkg::REG_IRQ_MASK) begin
                irq_mask <= wdata[lfl_pkg::IRQ_W-1:0];
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_mon_flagged: assert property (mon_above_ref_pin [*4] |-> cond.mon_over)
        else $error("monitor over reference not flagged");
    chk_pd_limit: assert property (({1'b0, pd_meas, 1'b0} > ({2'b00, pd_set} + {1'b0, pd_set, 1'b0}))
        |=> cond.pd_over)
        else $error("photodiode over limit not flagged");
    chk_dac_drop: assert property ((bias_wr && ({wdata[DAC_W-1:0], 1'b0} < {1'b0, bias_code}))
        |=> cond.dac_drop)
        else $error("bias drop not flagged");
    chk_fault_zeroes: assert property ((state != lfl_pkg::LFL_RUN || qualifying) |=> drive == '0)
        else $error("currents not forced to zero");
    chk_fault_latches: assert property ((state == lfl_pkg::LFL_RUN && qualifying && !disabled)
        |=> fault_latch ##1 (fault_output || disabled))
        else $error("fault not latched onto output");
    chk_clear_hold: assert property ($fell(fault_latch) |-> $past(disabled) && $past(tmr) == CLEAR_LAST)
        else $error("latch cleared before hold time");
    chk_fault_masked: assert property (disabled |=> !fault_output)
        else $error("fault output high while disabled");
    chk_resume: assert property ((state == lfl_pkg::LFL_WAKE && tmr == NEGATE_LAST && !disabled && !qualifying)
        |=> state == lfl_pkg::LFL_RUN)
        else $error("no resume after turn-on delay");
    chk_refault: assert property ((state == lfl_pkg::LFL_OFF && !disabled && qualifying)
        |=> state == lfl_pkg::LFL_FAULT ##1 fault_output)
        else $error("fault not reasserted at release");
    chk_mod_half: assert property ((state == lfl_pkg::LFL_RUN && !qualifying
        && range_cfg[lfl_pkg::RNG_MOD_LSB +: 2] == 2'b11) |=> drive.modul == ($past(mod_code) >> 1))
        else $error("half range scaling wrong");
    chk_irq_level: assert property (|(irq_stat & irq_mask) |=> irq)
        else $error("interrupt not raised");

    cov_fault_seen: cover property (state == lfl_pkg::LFL_RUN ##1 state == lfl_pkg::LFL_FAULT);
    cov_recover: cover property ($fell(fault_latch) ##[1:1000] state == lfl_pkg::LFL_WAKE);
    cov_refault: cover property (state == lfl_pkg::LFL_OFF && fault_latch ##1 state == lfl_pkg::LFL_FAULT);
    cov_drop: cover property (cond.dac_drop);

endmodule
